// ==== core/dcwd_core.v ====
// drive control word decoder with holding register port
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_regs.vh"

module dcwd_core #(
    parameter DW = 16
) (
    input  wire          sys_clk,
    input  wire          rst_n,
    input  wire          reg_wr,
    input  wire          reg_rd,
    input  wire [15:0]   reg_addr,
    input  wire [DW-1:0] reg_wdata,
    output reg  [DW-1:0] reg_rdata_ff,
    output reg           reg_rvalid_ff,
    output reg           reg_err_ff,
    input  wire          lower_area_en,
    input  wire [7:0]    protocol_sel,
    input  wire [7:0]    relay1_func,
    input  wire [7:0]    relay2_func,
    input  wire [7:0]    active_setup,
    input  wire [1:0]    coast_src,
    input  wire [1:0]    start_src,
    input  wire [1:0]    setup_src,
    input  wire [1:0]    preset_src,
    input  wire [1:0]    reverse_src,
    input  wire          di_coast_n,
    input  wire          di_start,
    input  wire          di_setup2,
    input  wire [1:0]    di_preset,
    input  wire          di_reverse,
    input  wire          di_dc_brake_n,
    input  wire          di_coast_reset_n,
    input  wire [DW-1:0] drive_state_word,
    input  wire [DW-1:0] actual_output_value,
    output reg  [1:0]    preset_idx_ff,
    output reg           dc_brake_ff,
    output reg           coast_ff,
    output reg           quick_stop_ff,
    output reg           freeze_ff,
    output reg           ramp_stop_ff,
    output reg           trip_reset_ff,
    output reg           jog_ff,
    output reg           ramp_set2_ff,
    output reg           relay1_ff,
    output reg           relay2_ff,
    output reg           setup2_ff,
    output reg           reverse_ff,
    output reg  [DW-1:0] speed_setpoint_ff
);

    // ==========================================================
    // source merge
    function merge;
        input [1:0] sel;
        input       bus_v;
        input       di_v;
        begin
            case (sel)
                `DCWD_SRC_DIGITAL: merge = di_v;
                `DCWD_SRC_BUS:     merge = bus_v;
                `DCWD_SRC_AND:     merge = bus_v & di_v;
                `DCWD_SRC_OR:      merge = bus_v | di_v;
                default:           merge = di_v;
            endcase
        end
    endfunction

    // ==========================================================
    // register decode
    reg  [DW-1:0] cmd_word_ff;
    reg  [DW-1:0] applied_ff;
    reg  [DW-1:0] setp_word_ff;
    wire          hit_cmd;
    wire          hit_setp;
    wire          hit_state;
    wire          hit_actual;
    wire          native;
    wire          take_cmd;

    assign hit_cmd    = (reg_addr == `DCWD_CMD_HI) |
                        (lower_area_en & (reg_addr == `DCWD_CMD_LO));
    assign hit_setp   = (reg_addr == `DCWD_SETP_HI) |
                        (lower_area_en & (reg_addr == `DCWD_SETP_LO));
    assign hit_state  = (reg_addr == `DCWD_STATE_HI) |
                        (lower_area_en & (reg_addr == `DCWD_STATE_LO));
    assign hit_actual = (reg_addr == `DCWD_ACTUAL_HI) |
                        (lower_area_en & (reg_addr == `DCWD_ACTUAL_LO));
    assign native     = (protocol_sel == `DCWD_PROTO_NATIVE);
    // word with data-valid low never reaches the decoder
    assign take_cmd   = reg_wr & hit_cmd & native &
                        reg_wdata[`DCWD_B_VALID];

    // ==========================================================
    // address map summary
    wire          any_hit;
    wire          wr_refused;

    assign any_hit    = hit_cmd | hit_setp | hit_state | hit_actual;
    // only the two input words take writes
    assign wr_refused = reg_wr & ~(hit_cmd | hit_setp);

    // ==========================================================
    // register storage and read port
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_word_ff   <= `DCWD_CMD_RST;
            setp_word_ff  <= `DCWD_SETP_RST;
            applied_ff    <= `DCWD_CMD_RST;
            reg_rdata_ff  <= {DW{1'b0}};
            reg_rvalid_ff <= 1'b0;
            reg_err_ff    <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            reg_err_ff    <= wr_refused;
            if (reg_wr) begin
                if (hit_cmd) begin
                    cmd_word_ff <= reg_wdata;
                end else if (hit_setp) begin
                    setp_word_ff <= reg_wdata;
                end
            end
            if (take_cmd) begin
                applied_ff <= reg_wdata;
            end
            if (reg_rd) begin
                reg_err_ff <= ~any_hit;
                if (hit_cmd) begin
                    reg_rdata_ff <= cmd_word_ff;
                end else if (hit_setp) begin
                    reg_rdata_ff <= setp_word_ff;
                end else if (hit_state) begin
                    reg_rdata_ff <= drive_state_word;
                end else if (hit_actual) begin
                    reg_rdata_ff <= actual_output_value;
                end else begin
                    reg_rdata_ff <= {DW{1'b0}};
                end
            end
        end
    end

    // ==========================================================
    // preset select lanes, merged per bit with the inputs
    wire [1:0] preset_bus;
    wire [1:0] preset_merged;

    assign preset_bus = applied_ff[`DCWD_B_PRESET_MSB:`DCWD_B_PRESET_LSB];

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1) begin : g_preset
            assign preset_merged[gp] = merge(preset_src, preset_bus[gp],
                                             di_preset[gp]);
        end
    endgenerate

    // ==========================================================
    // relay lanes, each gated by its own option code
    wire [1:0] relay_bit;
    wire [1:0] relay_opt_ok;
    wire [1:0] nxt_relay;

    assign relay_bit[0]    = applied_ff[`DCWD_B_RELAY1];
    assign relay_bit[1]    = applied_ff[`DCWD_B_RELAY2];
    assign relay_opt_ok[0] = (relay1_func == `DCWD_RELAY1_OPT);
    assign relay_opt_ok[1] = (relay2_func == `DCWD_RELAY2_OPT);

    genvar gr;
    generate
        for (gr = 0; gr < 2; gr = gr + 1) begin : g_relay
            assign nxt_relay[gr] = relay_bit[gr] & relay_opt_ok[gr];
        end
    endgenerate

    // ==========================================================
    // trip reset edge
    wire reset_bit_new;
    wire reset_bit_old;
    wire trip_edge;

    // a level held high across words must not re-trigger
    assign reset_bit_new = reg_wdata[`DCWD_B_RESET];
    assign reset_bit_old = applied_ff[`DCWD_B_RESET];
    assign trip_edge     = take_cmd & reset_bit_new & ~reset_bit_old;

    // ==========================================================
    // command decode
    reg  [1:0] nxt_preset_idx;
    reg        nxt_dc_brake;
    reg        nxt_coast;
    reg        nxt_quick_stop;
    reg        nxt_freeze;
    reg        nxt_ramp_stop;
    reg        nxt_setup2;
    reg        nxt_reverse;
    reg        bus_coast;
    reg        bus_start;
    reg        di_stop_inv;

    always @* begin
        // bit 14 is never looked at
        bus_coast   = ~applied_ff[`DCWD_B_NO_COAST];
        bus_start   = applied_ff[`DCWD_B_START];
        di_stop_inv = ~di_dc_brake_n | ~di_coast_reset_n;
        nxt_preset_idx = preset_merged;
        nxt_dc_brake = ~applied_ff[`DCWD_B_RAMP_NDC] | ~di_dc_brake_n;
        nxt_coast    = merge(coast_src, bus_coast, ~di_coast_n) |
                       ~di_coast_reset_n;
        nxt_freeze   = ~applied_ff[`DCWD_B_USE_RAMP];
        // inverse stop inputs release the hold before the stops see it
        if (di_stop_inv) begin
            nxt_freeze = 1'b0;
        end
        // a frozen output ignores ramp and quick stops
        nxt_quick_stop = ~applied_ff[`DCWD_B_NO_QSTOP] & ~nxt_freeze;
        nxt_ramp_stop  = ~merge(start_src, bus_start, di_start) &
                         ~nxt_freeze;
        if (active_setup == `DCWD_SETUP_MULTI) begin
            nxt_setup2 = merge(setup_src, applied_ff[`DCWD_B_SETUP2],
                               di_setup2);
        end else begin
            nxt_setup2 = 1'b0;
        end
        if (reverse_src == `DCWD_SRC_DIGITAL) begin
            nxt_reverse = di_reverse;
        end else begin
            nxt_reverse = merge(reverse_src, applied_ff[`DCWD_B_REVERSE],
                                di_reverse);
        end
    end

    // ==========================================================
    // action outputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            preset_idx_ff     <= 2'h0;
            dc_brake_ff       <= 1'b0;
            coast_ff          <= 1'b1;
            quick_stop_ff     <= 1'b0;
            freeze_ff         <= 1'b0;
            ramp_stop_ff      <= 1'b1;
            trip_reset_ff     <= 1'b0;
            jog_ff            <= 1'b0;
            ramp_set2_ff      <= 1'b0;
            speed_setpoint_ff <= {DW{1'b0}};
        end else begin
            preset_idx_ff <= nxt_preset_idx;
            dc_brake_ff   <= nxt_dc_brake;
            coast_ff      <= nxt_coast;
            quick_stop_ff <= nxt_quick_stop;
            freeze_ff     <= nxt_freeze;
            ramp_stop_ff  <= nxt_ramp_stop;
            // pulse on a taken word whose reset bit rose
            trip_reset_ff <= trip_edge;
            jog_ff        <= applied_ff[`DCWD_B_JOG];
            ramp_set2_ff  <= applied_ff[`DCWD_B_RAMP2];
            speed_setpoint_ff <= setp_word_ff;
        end
    end

    // ==========================================================
    // relay, set-up and direction outputs
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay1_ff  <= 1'b0;
            relay2_ff  <= 1'b0;
            setup2_ff  <= 1'b0;
            reverse_ff <= 1'b0;
        end else begin
            relay1_ff  <= nxt_relay[0];
            relay2_ff  <= nxt_relay[1];
            setup2_ff  <= nxt_setup2;
            reverse_ff <= nxt_reverse;
        end
    end

endmodule

`default_nettype wire

// ==== core/dcwd_regs.vh ====
// register numbers, command bit positions, reset values and option codes
`ifndef DCWD_REGS_VH
`define DCWD_REGS_VH

// holding register numbers, upper area
`define DCWD_CMD_HI        16'hC350
`define DCWD_SETP_HI       16'hC35A
`define DCWD_STATE_HI      16'hC418
`define DCWD_ACTUAL_HI     16'hC422
// holding register numbers, lower area
`define DCWD_CMD_LO        16'h0AFA
`define DCWD_SETP_LO       16'h0AFB
`define DCWD_STATE_LO      16'h0B5E
`define DCWD_ACTUAL_LO     16'h0B5F

// command word bit positions
`define DCWD_B_PRESET_LSB  0
`define DCWD_B_PRESET_MSB  1
`define DCWD_B_RAMP_NDC    2
`define DCWD_B_NO_COAST    3
`define DCWD_B_NO_QSTOP    4
`define DCWD_B_USE_RAMP    5
`define DCWD_B_START       6
`define DCWD_B_RESET       7
`define DCWD_B_JOG         8
`define DCWD_B_RAMP2       9
`define DCWD_B_VALID       10
`define DCWD_B_RELAY1      11
`define DCWD_B_RELAY2      12
`define DCWD_B_SETUP2      13
`define DCWD_B_REVERSE     15

// reset values
`define DCWD_CMD_RST       16'h0000
`define DCWD_SETP_RST      16'h0000

// option codes of the configuration inputs
`define DCWD_PROTO_NATIVE  8'h00
`define DCWD_RELAY1_OPT    8'h24
`define DCWD_RELAY2_OPT    8'h25
`define DCWD_SETUP_MULTI   8'h09
`define DCWD_SRC_DIGITAL   2'h0
`define DCWD_SRC_BUS       2'h1
`define DCWD_SRC_AND       2'h2
`define DCWD_SRC_OR        2'h3

`endif

// ==== test/dcwd_master.sv ====
// register port master standing in for the bus controller
`timescale 1ns/1ps
`default_nettype none
module dcwd_master (
    input  wire logic        sys_clk,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [15:0] reg_addr,
    output var  logic [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata_ff,
    input  wire logic        reg_err_ff
);
// ==========
// access task
initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
end
// one-edge strobe, answer sampled one edge later
task automatic xfer(input logic wr, input logic [15:0] a, d,
        output logic [15:0] q, output logic e);
    @(negedge sys_clk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    // error answer stands only in the cycle after the taking edge, read data holds
    q = reg_rdata_ff;
    e = reg_err_ff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released bus shows no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge sys_clk);
endtask
endmodule
`default_nettype wire

// ==== test/dcwd_properties.sv ====
// port assertions for the drive control word decoder
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_regs.vh"
module dcwd_props #(
    parameter DW = 16
) (
    input wire logic          sys_clk,
    input wire logic          rst_n,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [15:0]   reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic [DW-1:0] reg_rdata_ff,
    input wire logic          reg_rvalid_ff,
    input wire logic          reg_err_ff,
    input wire logic [7:0]    protocol_sel,
    input wire logic [7:0]    relay1_func,
    input wire logic [DW-1:0] drive_state_word,
    input wire logic          freeze_ff,
    input wire logic          quick_stop_ff,
    input wire logic          ramp_stop_ff,
    input wire logic          trip_reset_ff,
    input wire logic          jog_ff,
    input wire logic          relay1_ff
);
// ==========
// assertions
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
wire logic cmd_wr = reg_wr && reg_addr == `DCWD_CMD_HI;
rd_answer_a: assert property (reg_rvalid_ff == $past(reg_rd))
    else $error("read answer timing wrong");
state_read_a: assert property (reg_rd && reg_addr == `DCWD_STATE_HI |=>
    reg_rdata_ff == $past(drive_state_word) && !reg_err_ff)
    else $error("state word read wrong");
ro_write_a: assert property (reg_wr && reg_addr == `DCWD_STATE_HI |=>
    reg_err_ff) else $error("state word write not refused");
ignored_cmd_a: assert property ((cmd_wr && (!reg_wdata[10] ||
    protocol_sel != `DCWD_PROTO_NATIVE)) ##1 !reg_wr |=> $stable(jog_ff))
    else $error("ignored command acted on");
jog_follow_a: assert property ((cmd_wr && reg_wdata[10] &&
    protocol_sel == `DCWD_PROTO_NATIVE) ##1 !reg_wr |=>
    jog_ff == $past(reg_wdata[8], 2)) else $error("jog not following");
trip_pulse_a: assert property (trip_reset_ff |=> !trip_reset_ff)
    else $error("trip reset longer than one cycle");
freeze_hold_a: assert property (freeze_ff |->
    !quick_stop_ff && !ramp_stop_ff) else $error("stop while frozen");
relay_gate_a: assert property ($past(relay1_func) !=
    `DCWD_RELAY1_OPT |-> !relay1_ff) else $error("relay 1 not gated");
cover property (cmd_wr && reg_wdata[10]);
cover property (trip_reset_ff);
cover property (reg_err_ff);
endmodule
bind dcwd_core dcwd_props #(.DW(DW)) u_props (.*);
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the drive control word decoder
`timescale 1ns/1ps
`default_nettype none
`include "dcwd_regs.vh"
module testbench;
logic sys_clk, rst_n, lower_area_en, di_reverse, e, di_coast_reset_n;
logic di_dc_brake_n, reg_wr, reg_rd, reg_rvalid_ff, reg_err_ff;
logic [15:0] reg_addr, reg_wdata, reg_rdata_ff, q, speed_setpoint_ff;
logic [7:0] protocol_sel, relay1_func, active_setup;
logic [1:0] reverse_src, preset_idx_ff;
logic dc_brake_ff, coast_ff, quick_stop_ff, freeze_ff, ramp_stop_ff;
logic trip_reset_ff, jog_ff, ramp_set2_ff, relay1_ff, relay2_ff;
logic setup2_ff, reverse_ff;
logic di_coast_n, di_start, di_setup2;
logic [1:0] di_preset;
logic [7:0] relay2_func;
logic [15:0] drive_state_word, actual_output_value;
int err_total, num_checks, trips;
logic [15:0] wl [4] = '{16'h0478, 16'hBF25, 16'h4456, 16'h0C7F};
wire logic [12:0] outs = {preset_idx_ff, dc_brake_ff, coast_ff,
    quick_stop_ff, freeze_ff, ramp_stop_ff, jog_ff, ramp_set2_ff,
    relay1_ff, relay2_ff, setup2_ff, reverse_ff};
dcwd_master u_mst (.*);
dcwd_core u_dut (.*,
    .coast_src(`DCWD_SRC_BUS), .start_src(`DCWD_SRC_BUS),
    .setup_src(`DCWD_SRC_BUS), .preset_src(`DCWD_SRC_BUS));
// ==========
// helpers
initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
end
always @(negedge sys_clk) if (trip_reset_ff === 1'b1) trips++;
task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic rd(input logic [15:0] a);
    u_mst.xfer(1'b0, a, 16'h0000, q, e);
endtask
task automatic wcmd(input logic [15:0] c);
    u_mst.xfer(1'b1, `DCWD_CMD_HI, c, q, e);
    @(negedge sys_clk);
endtask
task automatic cmpo(input logic [15:0] c);
    logic fr;
    fr = !c[5] && di_dc_brake_n && di_coast_reset_n;
    chk({3'h0, outs}, {3'h0, c[1:0], !c[2] || !di_dc_brake_n,
        !c[3] || !di_coast_reset_n, !fr && !c[4], fr, !fr && !c[6],
        c[8], c[9], c[11] && relay1_func == `DCWD_RELAY1_OPT, c[12],
        c[13] && active_setup == `DCWD_SETUP_MULTI,
        c[15] && reverse_src[0]});
endtask
// ==========
// main sequence
initial begin
    {rst_n, lower_area_en, di_reverse} = 3'h0;
    {di_dc_brake_n, di_coast_reset_n} = 2'h3;
    {di_coast_n, di_start, di_setup2, di_preset} = 5'h10;
    relay2_func = `DCWD_RELAY2_OPT;
    {drive_state_word, actual_output_value} = {16'h1234, 16'hC000};
    {protocol_sel, relay1_func} = {`DCWD_PROTO_NATIVE, `DCWD_RELAY1_OPT};
    {active_setup, reverse_src} = {`DCWD_SETUP_MULTI, `DCWD_SRC_BUS};
    repeat (20) @(negedge sys_clk);
    chk({14'h0, coast_ff, ramp_stop_ff}, 16'h0003);
    rst_n = 1'b1;
    rd(`DCWD_STATE_HI);
    chk(q, 16'h1234);
    rd(`DCWD_ACTUAL_HI);
    chk(q, 16'hC000);
    rd(`DCWD_STATE_LO);
    chk({15'h0, e}, 16'h0001);
    lower_area_en = 1'b1;
    rd(`DCWD_ACTUAL_LO);
    chk(q, 16'hC000);
    u_mst.xfer(1'b1, `DCWD_STATE_HI, 16'h5555, q, e);
    chk({15'h0, e}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
        wcmd(wl[i]);
        cmpo(wl[i]);
        rd(`DCWD_CMD_LO);
        chk(q, wl[i]);
    end
    u_mst.xfer(1'b1, `DCWD_SETP_LO, 16'hE000, q, e);
    chk(speed_setpoint_ff, 16'hE000);
    rd(`DCWD_SETP_HI);
    chk(q, 16'hE000);
    for (int s = 0; s < 4; s++) begin
        reverse_src = s[1:0];
        wcmd(16'h8478);
        cmpo(16'h8478);
    end
    wcmd(16'h0000);
    cmpo(16'h8478);
    protocol_sel = 8'h01;
    wcmd(16'h0478);
    cmpo(16'h8478);
    protocol_sel = `DCWD_PROTO_NATIVE;
    trips = 0;
    wcmd(16'h0480);
    wcmd(16'h0480);
    wcmd(16'h0400);
    wcmd(16'h0480);
    chk(trips[15:0], 16'h0002);
    for (int k = 0; k < 3; k++) begin
        {di_dc_brake_n, di_coast_reset_n} = (k == 2) ? 2'h3 : 2'h2 >> k;
        wcmd(16'h040C);
        cmpo(16'h040C);
    end
    relay1_func = 8'h00;
    active_setup = 8'h00;
    wcmd(16'h7C78);
    cmpo(16'h7C78);
    stop_test();
end
initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    stop_test();
end
endmodule
`default_nettype wire
